//--- hw/lpq_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef LPQ_REGS_VH
`define LPQ_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LPQ_METERING_MODE_REG_TWO_ADDR      8'h0C
`define LPQ_SILENCE_ADDR    8'h11
`define LPQ_LINE_MEAS_ADDR  8'h20
`define LPQ_SAG_LVL_ADDR    8'h21
`define LPQ_SAG_CYC_ADDR    8'h22
`define LPQ_VPK_LVL_ADDR    8'h23
`define LPQ_IPK_LVL_ADDR    8'h24
`define LPQ_VPK_CAP_ADDR    8'h25
`define LPQ_IPK_CAP_ADDR    8'h26
`define LPQ_VPK_CLR_ADDR    8'h27
`define LPQ_IPK_CLR_ADDR    8'h28
`define LPQ_STAT3_ADDR      8'h29
`define LPQ_EN3_ADDR        8'h2A
`define LPQ_SMF_ADDR        8'h2B
`define LPQ_SME_ADDR        8'h2C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LPQ_METERING_MODE_REG_TWO_PERIOD_OR_FREQ_SELECT   0
`define LPQ_METERING_MODE_REG_TWO_LPF_BYP   1
`define LPQ_ST3_ZX          0
`define LPQ_ST3_SILENCE     1
`define LPQ_ST3_PKV         2
`define LPQ_ST3_PKI         3
`define LPQ_SM_SAG          0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LPQ_SILENCE_RST     12'h0FFF
`define LPQ_SAG_LVL_RST     16'h0000
`define LPQ_SAG_CYC_RST     8'h04
`define LPQ_VPK_LVL_RST     16'hFFFF
`define LPQ_IPK_LVL_RST     16'hFFFF

// ---------------------------------------------------------------
// Timing counts in master-clock cycles
// ---------------------------------------------------------------
`define LPQ_SILENCE_TICK    8'd160
`define LPQ_PERIOD_TICK     4'd10
// 4.096 MHz * 16 counts per Hz / 10 clocks per period count
`define LPQ_FREQ_NUM        32'd6553600

`endif

//--- hw/lpq_divider.v
// Sequential divider turning period counts into frequency counts
`timescale 1ns/1ps
module lpq_divider
(
  input wire clk_sys,
  input wire rstn,
  input wire start,
  input wire [31:0] numer,
  input wire [31:0] denom,
  output reg busy,
  output reg [15:0] quot
);
  reg [31:0] rem_q;
  reg [31:0] num_q;
  reg [31:0] den_q;
  reg [31:0] quo_q;
  reg [5:0] cnt_q;
  wire [32:0] trial;

  // Restoring division, one quotient bit per clock
  assign trial = {rem_q, num_q[31]} - {1'b0, den_q};

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      quot <= 16'h0000;
      rem_q <= 32'h0000_0000;
      num_q <= 32'h0000_0000;
      den_q <= 32'h0000_0000;
      quo_q <= 32'h0000_0000;
      cnt_q <= 6'd0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      rem_q <= 32'h0000_0000;
      num_q <= numer;
      den_q <= denom;
      quo_q <= 32'h0000_0000;
      cnt_q <= 6'd32;
    end
    else if (busy)
    begin
      num_q <= {num_q[30:0], 1'b0};
      if (!trial[32])
      begin
        rem_q <= trial[31:0];
        quo_q <= {quo_q[30:0], 1'b1};
      end
      else
      begin
        rem_q <= {rem_q[30:0], num_q[31]};
        quo_q <= {quo_q[30:0], 1'b0};
      end
      cnt_q <= cnt_q - 6'd1;
      if (cnt_q == 6'd1)
      begin
        busy <= 1'b0;
        // Saturate rather than wrap on very fast lines
        if (!trial[32])
          quot <= (quo_q[30:15] != 16'h0000) ? 16'hFFFF :
                  {quo_q[14:0], 1'b1};
        else
          quot <= (quo_q[30:15] != 16'h0000) ? 16'hFFFF :
                  {quo_q[14:0], 1'b0};
      end
    end
  end
endmodule // lpq_divider

//--- hw/lpq_monitor.v
// Line power-quality supervisor: crossings, silence, period, sag, peaks
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - Crossings come from filtered voltage unless software selects bypass.
// - Each crossing sets its status flag; enabled flag raises metering irq.
// - Crossing irq stays asserted until software clears the flag.
// - Twelve-bit silence countdown decrements once every 160 clocks.
// - Every crossing reloads the countdown with the programmed start.
// - Programmed start value is 0xFFF after reset.
// - Countdown reaching zero sets timeout flag; enabled flag raises irq.
// - Start value is readable and writable at 0x11, 160 clocks per LSB.
// - Mode bit picks period when clear, frequency when set.
// - Period or frequency result is unsigned 16-bit, refreshed each period.
// - Period counts in units of ten master-clock cycles.
// - Frequency counts in sixteenths of a hertz at nominal clock.
// - Sag count 0 or 1 is invalid; count is cycles plus one.
// - Sag sets supply-monitor flag; enabled flag raises supply irq.
// - Sag when threshold exceeds absolute selected voltage (filtered, or raw in bypass).
// - Both channels' upper sixteen bits compared against peak thresholds.
// - Exceeding peak levels sets voltage or current peak flags.
// - Peak irq stays asserted until software clears the peak flag.
// - Capture registers hold largest absolute sample per channel.
// - Reading a clearing alias returns value then zeroes the capture.
module lpq_monitor
(
  input wire clk_sys,
  input wire rstn,
  input wire [15:0] v_filt,
  input wire [15:0] v_raw,
  input wire v_valid,
  input wire [23:0] i_samp,
  input wire i_valid,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg zero_cross_event,
  output wire metering_irq,
  output wire supply_monitor_irq
);
`include "lpq_regs.vh"

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function [15:0] abs16;
    input [15:0] x;
    begin
      abs16 = x[15] ? (~x + 16'h0001) : x;
    end
  endfunction

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  reg [1:0] metering_mode_reg_two_q;
  reg [11:0] silence_start_q;
  reg [15:0] sag_lvl_q;
  reg [7:0] sag_cyc_q;
  reg [15:0] vpk_lvl_q;
  reg [15:0] ipk_lvl_q;
  reg [15:0] vpk_cap_q;
  reg [15:0] ipk_cap_q;
  reg [3:0] stat3_q;
  reg [3:0] en3_q;
  reg smf_q;
  reg sme_q;
  reg [15:0] line_meas_q;

  wire wr_stat3 = reg_wr && (reg_addr == `LPQ_STAT3_ADDR);
  wire wr_smf = reg_wr && (reg_addr == `LPQ_SMF_ADDR);
  wire rd_vclr = reg_rd && (reg_addr == `LPQ_VPK_CLR_ADDR);
  wire rd_iclr = reg_rd && (reg_addr == `LPQ_IPK_CLR_ADDR);

  // -------------------------------------------------------------
  // Crossing detection
  // -------------------------------------------------------------
  wire [15:0] v_sel = metering_mode_reg_two_q[`LPQ_METERING_MODE_REG_TWO_LPF_BYP] ? v_raw : v_filt;
  reg v_sign_q;
  reg v_seen_q;
  wire zx = v_valid && v_seen_q && v_sign_q && !v_sel[15];

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      v_sign_q <= 1'b0;
      v_seen_q <= 1'b0;
      zero_cross_event <= 1'b0;
    end
    else
    begin
      zero_cross_event <= zx;
      if (v_valid)
      begin
        v_sign_q <= v_sel[15];
        v_seen_q <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // Silence countdown
  // -------------------------------------------------------------
  reg [7:0] tick_q;
  reg [11:0] silence_q;
  reg silence_hit;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tick_q <= 8'd0;
      silence_q <= `LPQ_SILENCE_RST;
      silence_hit <= 1'b0;
    end
    else
    begin
      silence_hit <= 1'b0;
      if (zx)
      begin
        silence_q <= silence_start_q;
        tick_q <= 8'd0;
      end
      else if (tick_q == `LPQ_SILENCE_TICK - 8'd1)
      begin
        tick_q <= 8'd0;
        // Hold at zero so the flag fires once per silent stretch
        if (silence_q != 12'h000)
        begin
          silence_q <= silence_q - 12'h001;
          if (silence_q == 12'h001)
            silence_hit <= 1'b1;
        end
      end
      else
        tick_q <= tick_q + 8'd1;
    end
  end

  // -------------------------------------------------------------
  // Period and frequency measurement
  // -------------------------------------------------------------
  reg [3:0] pdiv_q;
  reg [15:0] pcnt_q;
  reg [15:0] period_q;
  reg div_start_q;
  wire div_busy;
  wire [15:0] div_quot;
  reg div_busy_q;

  lpq_divider u_div
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(div_start_q),
    .numer(`LPQ_FREQ_NUM),
    .denom({16'h0000, period_q}),
    .busy(div_busy),
    .quot(div_quot)
  );

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pdiv_q <= 4'd0;
      pcnt_q <= 16'h0000;
      period_q <= 16'h0000;
      div_start_q <= 1'b0;
      div_busy_q <= 1'b0;
      line_meas_q <= 16'h0000;
    end
    else
    begin
      div_start_q <= 1'b0;
      div_busy_q <= div_busy;
      if (zx)
      begin
        period_q <= pcnt_q;
        pcnt_q <= 16'h0000;
        pdiv_q <= 4'd0;
        if (!metering_mode_reg_two_q[`LPQ_METERING_MODE_REG_TWO_PERIOD_OR_FREQ_SELECT])
          line_meas_q <= pcnt_q;
        else if (pcnt_q != 16'h0000)
          div_start_q <= 1'b1;
      end
      else if (pdiv_q == `LPQ_PERIOD_TICK - 4'd1)
      begin
        pdiv_q <= 4'd0;
        if (pcnt_q != 16'hFFFF)
          pcnt_q <= pcnt_q + 16'h0001;
      end
      else
        pdiv_q <= pdiv_q + 4'd1;
      if (div_busy_q && !div_busy && metering_mode_reg_two_q[`LPQ_METERING_MODE_REG_TWO_PERIOD_OR_FREQ_SELECT])
        line_meas_q <= div_quot;
    end
  end

  // -------------------------------------------------------------
  // Sag detection, one decision per line cycle
  // -------------------------------------------------------------
  reg cyc_high_q;
  reg [7:0] sag_cnt_q;
  reg sag_hit;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cyc_high_q <= 1'b0;
      sag_cnt_q <= 8'd0;
      sag_hit <= 1'b0;
    end
    else
    begin
      sag_hit <= 1'b0;
      if (zx)
      begin
        cyc_high_q <= 1'b0;
        if (cyc_high_q)
          sag_cnt_q <= 8'd0;
        else if (sag_cnt_q != 8'hFF)
        begin
          sag_cnt_q <= sag_cnt_q + 8'd1;
          // Limit counts one more than the low cycles required
          // Nine bits so a limit of 0 or 1 can never match
          if ({1'b0, sag_cnt_q} + 9'd2 == {1'b0, sag_cyc_q})
            sag_hit <= 1'b1;
        end
      end
      else if (v_valid && !(sag_lvl_q > abs16(v_sel)))
        cyc_high_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Peak thresholds and capture
  // -------------------------------------------------------------
  wire [15:0] v_abs = abs16(v_sel);
  wire [15:0] i_abs = abs16(i_samp[23:8]);
  wire pkv_hit = v_valid && (v_abs > vpk_lvl_q);
  wire pki_hit = i_valid && (i_abs > ipk_lvl_q);

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      vpk_cap_q <= 16'h0000;
      ipk_cap_q <= 16'h0000;
    end
    else
    begin
      // New larger sample wins over the clearing read
      if (v_valid && v_abs > vpk_cap_q)
        vpk_cap_q <= v_abs;
      else if (rd_vclr)
        vpk_cap_q <= 16'h0000;
      if (i_valid && i_abs > ipk_cap_q)
        ipk_cap_q <= i_abs;
      else if (rd_iclr)
        ipk_cap_q <= 16'h0000;
    end
  end

  // -------------------------------------------------------------
  // Status flags: write one to clear, hardware set wins
  // -------------------------------------------------------------
  wire [3:0] st3_set = {pki_hit, pkv_hit, silence_hit, zx};

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stat3_q <= 4'h0;
      smf_q <= 1'b0;
    end
    else
    begin
      stat3_q <= (stat3_q & ~(wr_stat3 ? reg_wdata[3:0] : 4'h0))
                 | st3_set;
      if (sag_hit)
        smf_q <= 1'b1;
      else if (wr_smf && reg_wdata[`LPQ_SM_SAG])
        smf_q <= 1'b0;
    end
  end

  assign metering_irq = |(stat3_q & en3_q);
  assign supply_monitor_irq = smf_q & sme_q;

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      metering_mode_reg_two_q <= 2'b00;
      silence_start_q <= `LPQ_SILENCE_RST;
      sag_lvl_q <= `LPQ_SAG_LVL_RST;
      sag_cyc_q <= `LPQ_SAG_CYC_RST;
      vpk_lvl_q <= `LPQ_VPK_LVL_RST;
      ipk_lvl_q <= `LPQ_IPK_LVL_RST;
      en3_q <= 4'h0;
      sme_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `LPQ_METERING_MODE_REG_TWO_ADDR: metering_mode_reg_two_q <= reg_wdata[1:0];
        `LPQ_SILENCE_ADDR: silence_start_q <= reg_wdata[11:0];
        `LPQ_SAG_LVL_ADDR: sag_lvl_q <= reg_wdata;
        `LPQ_SAG_CYC_ADDR: sag_cyc_q <= reg_wdata[7:0];
        `LPQ_VPK_LVL_ADDR: vpk_lvl_q <= reg_wdata;
        `LPQ_IPK_LVL_ADDR: ipk_lvl_q <= reg_wdata;
        `LPQ_EN3_ADDR: en3_q <= reg_wdata[3:0];
        `LPQ_SME_ADDR: sme_q <= reg_wdata[0];
        default: sme_q <= sme_q;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // -------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `LPQ_METERING_MODE_REG_TWO_ADDR: reg_rdata <= {14'h0000, metering_mode_reg_two_q};
        `LPQ_SILENCE_ADDR: reg_rdata <= {4'h0, silence_start_q};
        `LPQ_LINE_MEAS_ADDR: reg_rdata <= line_meas_q;
        `LPQ_SAG_LVL_ADDR: reg_rdata <= sag_lvl_q;
        `LPQ_SAG_CYC_ADDR: reg_rdata <= {8'h00, sag_cyc_q};
        `LPQ_VPK_LVL_ADDR: reg_rdata <= vpk_lvl_q;
        `LPQ_IPK_LVL_ADDR: reg_rdata <= ipk_lvl_q;
        `LPQ_VPK_CAP_ADDR: reg_rdata <= vpk_cap_q;
        `LPQ_IPK_CAP_ADDR: reg_rdata <= ipk_cap_q;
        `LPQ_VPK_CLR_ADDR: reg_rdata <= vpk_cap_q;
        `LPQ_IPK_CLR_ADDR: reg_rdata <= ipk_cap_q;
        `LPQ_STAT3_ADDR: reg_rdata <= {12'h000, stat3_q};
        `LPQ_EN3_ADDR: reg_rdata <= {12'h000, en3_q};
        `LPQ_SMF_ADDR: reg_rdata <= {15'h0000, smf_q};
        `LPQ_SME_ADDR: reg_rdata <= {15'h0000, sme_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
endmodule // lpq_monitor

//--- verif/lpq_monitor_checker.sv
// Port-level assertions for the power-quality monitor
`timescale 1ns/1ps
`include "lpq_regs.vh"
module lpq_monitor_checker
(
  input wire clk_sys,
  input wire rstn,
  input wire [15:0] v_filt,
  input wire [15:0] v_raw,
  input wire v_valid,
  input wire [23:0] i_samp,
  input wire i_valid,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire zero_cross_event,
  input wire metering_irq,
  input wire supply_monitor_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_start_width: assert property (reg_rd &&
    reg_addr == `LPQ_SILENCE_ADDR |=> reg_rdata[15:12] == 4'h0)
    else $error("silence start wider than 12 bits");
  a_zx_single: assert property (zero_cross_event |=> !zero_cross_event)
    else $error("crossing pulse too long");
  a_zx_cause: assert property (zero_cross_event |-> $past(v_valid))
    else $error("crossing without a sample");
  a_irq_clear: assert property ($fell(metering_irq) |-> $past(reg_wr) &&
    ($past(reg_addr) == `LPQ_STAT3_ADDR || $past(reg_addr) == `LPQ_EN3_ADDR))
    else $error("metering irq dropped without software");
  a_sag_clear: assert property ($fell(supply_monitor_irq) |->
    $past(reg_wr) && ($past(reg_addr) == `LPQ_SMF_ADDR ||
    $past(reg_addr) == `LPQ_SME_ADDR))
    else $error("supply irq dropped without software");
  a_sag_cause: assert property ($rose(supply_monitor_irq) |->
    $past(v_valid, 2) || $past(reg_wr))
    else $error("supply irq without cause");
endmodule // lpq_monitor_checker

bind lpq_monitor lpq_monitor_checker u_chk
(
  .clk_sys(clk_sys), .rstn(rstn), .v_filt(v_filt), .v_raw(v_raw),
  .v_valid(v_valid), .i_samp(i_samp), .i_valid(i_valid),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .zero_cross_event(zero_cross_event), .metering_irq(metering_irq),
  .supply_monitor_irq(supply_monitor_irq)
);

//--- verif/lpq_src_model.sv
// Upstream voltage and current sample source model
`timescale 1ns/1ps
module lpq_src_model
(
  input wire clk_sys,
  output reg [15:0] v_filt,
  output reg [15:0] v_raw,
  output reg v_valid,
  output reg [23:0] i_samp,
  output reg i_valid
);
  initial
  begin
    v_filt = 16'h0000;
    v_raw = 16'h0000;
    i_samp = 24'h00_0000;
    v_valid = 1'b0;
    i_valid = 1'b0;
  end
  // Both channels arrive together; data scrambled outside the valid pulse
  task send(input [15:0] f, input [15:0] r, input [23:0] c);
    begin
      @(posedge clk_sys);
      v_filt <= f;
      v_raw <= r;
      i_samp <= c;
      v_valid <= 1'b1;
      i_valid <= 1'b1;
      @(posedge clk_sys);
      v_filt <= ~f;
      v_raw <= ~r;
      i_samp <= ~c;
      v_valid <= 1'b0;
      i_valid <= 1'b0;
    end
  endtask
endmodule // lpq_src_model

//--- verif/lpq_monitor_bench.sv
// Self-checking bench for the power-quality monitor
`timescale 1ns/1ps
`include "lpq_regs.vh"
module lpq_monitor_bench;
  reg clk_sys;
  reg rstn;
  reg [7:0] reg_addr;
  reg [15:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg [15:0] c;
  wire [15:0] reg_rdata, v_filt, v_raw;
  wire [23:0] i_samp;
  wire v_valid, i_valid, zx, m_irq, s_irq;
  integer n_mismatch, tests_run, zx_cnt;

  lpq_src_model src(.clk_sys(clk_sys), .v_filt(v_filt), .v_raw(v_raw),
    .v_valid(v_valid), .i_samp(i_samp), .i_valid(i_valid));
  lpq_monitor dut(.clk_sys(clk_sys), .rstn(rstn), .v_filt(v_filt),
    .v_raw(v_raw), .v_valid(v_valid), .i_samp(i_samp), .i_valid(i_valid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zero_cross_event(zx),
    .metering_irq(m_irq), .supply_monitor_irq(s_irq));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (zx === 1'b1)
      zx_cnt <= zx_cnt + 1;

  task chk(input [15:0] got, input [15:0] lo, input [15:0] hi);
    begin
      tests_run = tests_run + 1;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t got %h want %h..%h", $time, got, lo, hi);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] v);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  // Answer stands only in the cycle after the strobe
  task rdchk(input [7:0] a, input [15:0] lo, input [15:0] hi);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, lo, hi);
    end
  endtask
  task xing(input [15:0] m);
    begin
      src.send(-m, -m, 24'h00_0000);
      src.send(m, m, 24'h00_0000);
    end
  endtask
  task stop_test;
    begin
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task t_regs;
    begin
      rdchk(`LPQ_SILENCE_ADDR, 16'h0FFF, 16'h0FFF);
      rdchk(`LPQ_SAG_CYC_ADDR, 16'h0004, 16'h0004);
      rdchk(`LPQ_VPK_LVL_ADDR, 16'hFFFF, 16'hFFFF);
      rdchk(8'h00, 16'h0000, 16'h0000);
      wr(`LPQ_SILENCE_ADDR, 16'hF123);
      rdchk(`LPQ_SILENCE_ADDR, 16'h0123, 16'h0123);
      $display("t_regs done");
    end
  endtask
  task t_peak;
    begin
      wr(`LPQ_VPK_LVL_ADDR, 16'h1000);
      wr(`LPQ_IPK_LVL_ADDR, 16'h2000);
      wr(`LPQ_EN3_ADDR, 16'h000C);
      rdchk(`LPQ_VPK_CLR_ADDR, 16'h0000, 16'h0000);
      rdchk(`LPQ_IPK_CLR_ADDR, 16'h0000, 16'h0000);
      wr(`LPQ_STAT3_ADDR, 16'h000F);
      src.send(16'h1000, 16'h1000, 24'h20_0000);
      repeat (2) @(posedge clk_sys);
      chk({15'h0000, m_irq}, 16'h0000, 16'h0000);
      src.send(16'hEFFF, 16'hEFFF, 24'hDF_FF00);
      rdchk(`LPQ_STAT3_ADDR, 16'h000C, 16'h000C);
      rdchk(`LPQ_VPK_CAP_ADDR, 16'h1001, 16'h1001);
      rdchk(`LPQ_IPK_CAP_ADDR, 16'h2001, 16'h2001);
      rdchk(`LPQ_VPK_CLR_ADDR, 16'h1001, 16'h1001);
      rdchk(`LPQ_VPK_CAP_ADDR, 16'h0000, 16'h0000);
      rdchk(`LPQ_IPK_CLR_ADDR, 16'h2001, 16'h2001);
      rdchk(`LPQ_IPK_CAP_ADDR, 16'h0000, 16'h0000);
      wr(`LPQ_STAT3_ADDR, 16'h0004);
      chk({15'h0000, m_irq}, 16'h0001, 16'h0001);
      wr(`LPQ_STAT3_ADDR, 16'h0008);
      chk({15'h0000, m_irq}, 16'h0000, 16'h0000);
      wr(`LPQ_EN3_ADDR, 16'h0000);
      $display("t_peak done");
    end
  endtask
  task t_zx;
    begin
      wr(`LPQ_EN3_ADDR, 16'h0001);
      wr(`LPQ_STAT3_ADDR, 16'h000F);
      c = zx_cnt[15:0];
      xing(16'h0100);
      src.send(16'h0100, 16'h0100, 24'h00_0000);
      src.send(16'hFF00, 16'hFF00, 24'h00_0000);
      chk(zx_cnt[15:0], c + 16'h0001, c + 16'h0001);
      chk({15'h0000, m_irq}, 16'h0001, 16'h0001);
      repeat (50) @(posedge clk_sys);
      chk({15'h0000, m_irq}, 16'h0001, 16'h0001);
      wr(`LPQ_STAT3_ADDR, 16'h0001);
      chk({15'h0000, m_irq}, 16'h0000, 16'h0000);
      wr(`LPQ_METERING_MODE_REG_TWO_ADDR, 16'h0002);
      // Only the raw channel crosses while bypassed
      src.send(16'hFF00, 16'hFF00, 24'h00_0000);
      src.send(16'hFF00, 16'h0100, 24'h00_0000);
      wr(`LPQ_METERING_MODE_REG_TWO_ADDR, 16'h0000);
      src.send(16'hFF00, 16'h0100, 24'h00_0000);
      src.send(16'h0100, 16'h0100, 24'h00_0000);
      src.send(16'h0100, 16'hFF00, 24'h00_0000);
      src.send(16'h0100, 16'h0100, 24'h00_0000);
      repeat (2) @(posedge clk_sys);
      chk(zx_cnt[15:0], c + 16'h0003, c + 16'h0003);
      wr(`LPQ_EN3_ADDR, 16'h0000);
      $display("t_zx done");
    end
  endtask
  task t_silence;
    begin
      wr(`LPQ_SILENCE_ADDR, 16'h0003);
      wr(`LPQ_EN3_ADDR, 16'h0002);
      xing(16'h0100);
      wr(`LPQ_STAT3_ADDR, 16'h000F);
      repeat (450) @(posedge clk_sys);
      chk({15'h0000, m_irq}, 16'h0000, 16'h0000);
      repeat (50) @(posedge clk_sys);
      chk({15'h0000, m_irq}, 16'h0001, 16'h0001);
      wr(`LPQ_STAT3_ADDR, 16'h0002);
      chk({15'h0000, m_irq}, 16'h0000, 16'h0000);
      wr(`LPQ_SILENCE_ADDR, 16'h0FFF);
      xing(16'h0100);
      wr(`LPQ_EN3_ADDR, 16'h0000);
      $display("t_silence done");
    end
  endtask
  task t_sag;
    begin
      wr(`LPQ_SAG_LVL_ADDR, 16'h1000);
      wr(`LPQ_SAG_CYC_ADDR, 16'h0003);
      wr(`LPQ_SME_ADDR, 16'h0001);
      src.send(16'h3000, 16'h3000, 24'h00_0000);
      xing(16'h0100);
      xing(16'h0100);
      src.send(16'h3000, 16'h3000, 24'h00_0000);
      xing(16'h0100);
      xing(16'h0100);
      repeat (2) @(posedge clk_sys);
      chk({15'h0000, s_irq}, 16'h0000, 16'h0000);
      xing(16'h0100);
      // Flag lands two edges after the crossing sample
      repeat (2) @(posedge clk_sys);
      chk({15'h0000, s_irq}, 16'h0001, 16'h0001);
      wr(`LPQ_SMF_ADDR, 16'h0001);
      chk({15'h0000, s_irq}, 16'h0000, 16'h0000);
      wr(`LPQ_SME_ADDR, 16'h0000);
      $display("t_sag done");
    end
  endtask
  // Line period of 20480 clocks: 2048 tens, 3200 sixteenths of a hertz
  task t_period;
    begin
      wr(`LPQ_METERING_MODE_REG_TWO_ADDR, 16'h0000);
      xing(16'h0100);
      repeat (20476) @(posedge clk_sys);
      xing(16'h0100);
      repeat (40) @(posedge clk_sys);
      rdchk(`LPQ_LINE_MEAS_ADDR, 16'h07FE, 16'h0802);
      wr(`LPQ_METERING_MODE_REG_TWO_ADDR, 16'h0001);
      repeat (20431) @(posedge clk_sys);
      xing(16'h0100);
      repeat (40) @(posedge clk_sys);
      rdchk(`LPQ_LINE_MEAS_ADDR, 16'h0C7C, 16'h0C84);
      $display("t_period done");
    end
  endtask

  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    zx_cnt = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_peak;
    t_zx;
    t_silence;
    t_sag;
    t_period;
    stop_test;
  end
  initial
  begin
    #4000000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule // lpq_monitor_bench
